// [hdl/buck_charger_gate_drive_control.sv]
// soft start, switching cycle and gate drive for a synchronous buck charger
// Notes on behaviour
// - every enable restarts the soft-start ramp at its lowest step.
// - eight equal current steps, each below the top held about 1.7 ms; the top step holds until charging stops.
// - switching cycles at a fixed 300 kHz from the internal time base.
// - no high side when error is below ramp; full duty still leaves both dead gaps off, 12 of 666 cycles when synchronous.
// - bootstrap low over three cycles: high side off, low side recharges.
// - non-synchronous once undercurrent reported, until rising current is reported; starts non-synchronous after reset.
// - synchronous low side complements high side with 30 ns dead gaps.
// - non-synchronous low side pulses 80 ns after dead time, then rests.
// - non-synchronous with bootstrap low: only the 80 ns pulse, no high side.
// - undercurrent uses falling 13 mV and rising 21 mV comparator hysteresis.
// - input overvoltage stops charging, adapter switch off, battery on.
// - overvoltage does not latch; normal operation resumes once it clears.
// - input current monitor held at ground until supply and detect valid.
`timescale 1ns/1ps
`default_nettype none
module buck_charger_gate_drive_control #(
  parameter int STEP_CYCLES = charger_pkg::STEP_CYCLES_DEF,
  parameter int STEP_W = 19
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire charger_pkg::sense_type sense_pins,
  output var charger_pkg::gate_type gate_drive,
  output var charger_pkg::path_type path_drive,
  output var logic [2:0] current_step,
  output var logic nonsync_mode
);
  import charger_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  sense_type meta_q;
  sense_type sense_q;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= '0;
      sense_q <= '0;
    end else begin
      meta_q <= sense_pins;
      sense_q <= meta_q;
    end
  end

  logic run;
  // overvoltage only gates, never latches
  assign run = sense_q.charge_enable && !sense_q.adapter_overvoltage;

  // ****************************************************************
  // soft start
  // ****************************************************************
  logic [2:0] step_q, step_d;
  logic [STEP_W-1:0] timer_q, timer_d;
  logic run_q, run_d;
  always_comb begin
    step_d = step_q;
    timer_d = timer_q;
    run_d = run;
    if (!run) begin
      step_d = STEP_RESET;
      timer_d = '0;
    end else if (!run_q) begin
      step_d = STEP_RESET;
      timer_d = '0;
    end else if (timer_q == STEP_W'(STEP_CYCLES - 1)) begin
      timer_d = '0;
      if (step_q != 3'(SS_STEPS - 1)) begin
        step_d = step_q + 3'h1;
      end
    end else begin
      timer_d = timer_q + STEP_W'(1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      step_q <= STEP_RESET;
      timer_q <= '0;
      run_q <= 1'b0;
    end else begin
      step_q <= step_d;
      timer_q <= timer_d;
      run_q <= run_d;
    end
  end

  // ****************************************************************
  // conduction mode with hysteresis
  // ****************************************************************
  logic nonsync_q, nonsync_d;
  always_comb begin
    nonsync_d = nonsync_q;
    if (sense_q.current_below_fall) begin
      nonsync_d = 1'b1;
    end else if (sense_q.current_above_rise) begin
      nonsync_d = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nonsync_q <= NONSYNC_RESET;
    end else begin
      nonsync_q <= nonsync_d;
    end
  end

  // ****************************************************************
  // switching period
  // ****************************************************************
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic cycle_start;
  always_comb begin
    if (!run || cnt_q == CNT_W'(PERIOD_CYCLES - 1)) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end
  assign cycle_start = run && (cnt_q == '0);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // gate drive sequencer
  // ****************************************************************
  phase_type state_q, state_d;
  logic [DLY_W-1:0] dly_q, dly_d;
  logic [1:0] boot_cnt_q, boot_cnt_d;
  logic pend_q, pend_d;
  logic mode_q, mode_d;
  logic hs_q, hs_d, ls_q, ls_d;
  logic begin_cycle;
  logic refresh_now;
  logic hs_want;
  // a cycle start that lands inside a dead gap or pulse waits in pend_q
  always_comb begin
    state_d = state_q;
    dly_d = dly_q;
    boot_cnt_d = boot_cnt_q;
    mode_d = mode_q;
    pend_d = pend_q || cycle_start;
    begin_cycle = 1'b0;
    refresh_now = sense_q.bootstrap_low &&
      (nonsync_q || boot_cnt_q == 2'(BOOT_LOW_LIMIT));
    hs_want = !refresh_now && sense_q.error_above_ramp;
    unique case (state_q)
      S_IDLE, S_LOW_SYNC, S_REST: begin
        begin_cycle = pend_d;
      end
      S_DEAD_ON: begin
        if (dly_q == DLY_W'(DEAD_CYCLES - 1)) begin
          state_d = S_HIGH;
          dly_d = '0;
        end else begin
          dly_d = dly_q + DLY_W'(1);
        end
      end
      S_HIGH: begin
        if (!sense_q.error_above_ramp ||
            cnt_q >= CNT_W'(PERIOD_CYCLES - MIN_OFF_CYCLES)) begin
          state_d = S_DEAD_OFF;
          dly_d = '0;
        end
      end
      S_DEAD_OFF: begin
        if (dly_q == DLY_W'(DEAD_CYCLES - 1)) begin
          dly_d = '0;
          // the recharge pulse goes first; a held start waits for rest
          if (mode_q) begin
            state_d = S_LOW_PULSE;
          end else if (pend_d) begin
            begin_cycle = 1'b1;
          end else begin
            state_d = S_LOW_SYNC;
          end
        end else begin
          dly_d = dly_q + DLY_W'(1);
        end
      end
      S_LOW_PULSE: begin
        if (dly_q == DLY_W'(PULSE_CYCLES - 1)) begin
          state_d = S_REST;
          dly_d = '0;
        end else begin
          dly_d = dly_q + DLY_W'(1);
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (begin_cycle) begin
      pend_d = 1'b0;
      mode_d = nonsync_q;
      dly_d = '0;
      if (refresh_now) begin
        boot_cnt_d = 2'h0;
      end else if (sense_q.bootstrap_low) begin
        boot_cnt_d = boot_cnt_q + 2'h1;
      end else begin
        boot_cnt_d = 2'h0;
      end
      if (hs_want) begin
        state_d = S_DEAD_ON;
      end else if (state_q == S_LOW_SYNC && !nonsync_q) begin
        state_d = S_LOW_SYNC;
      end else begin
        state_d = S_DEAD_OFF;
      end
    end
    if (!run) begin
      state_d = S_IDLE;
      dly_d = '0;
      pend_d = 1'b0;
      boot_cnt_d = 2'h0;
    end
    hs_d = (state_d == S_HIGH);
    ls_d = (state_d == S_LOW_SYNC) || (state_d == S_LOW_PULSE);
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      dly_q <= '0;
      boot_cnt_q <= 2'h0;
      pend_q <= 1'b0;
      mode_q <= NONSYNC_RESET;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dly_q <= dly_d;
      boot_cnt_q <= boot_cnt_d;
      pend_q <= pend_d;
      mode_q <= mode_d;
      hs_q <= hs_d;
      ls_q <= ls_d;
    end
  end

  // ****************************************************************
  // power path and monitor
  // ****************************************************************
  path_type path_q, path_d;
  always_comb begin
    path_d.input_overvoltage = sense_q.adapter_overvoltage;
    path_d.adapter_switch_drive = sense_q.select_adapter &&
      !sense_q.adapter_overvoltage;
    path_d.battery_switch_drive = !sense_q.select_adapter ||
      sense_q.adapter_overvoltage;
    path_d.input_current_monitor_enable = sense_q.supply_above_5v &&
      sense_q.adapter_above_0p6v;
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path_q <= '0;
    end else begin
      path_q <= path_d;
    end
  end

  assign gate_drive = '{high_side_drive: hs_q, low_side_drive: ls_q};
  assign path_drive = path_q;
  assign current_step = step_q;
  assign nonsync_mode = mode_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [CNT_W-1:0] hs_len_q;
  always_ff @(posedge core_clk) begin
    if (srst || !hs_q) begin
      hs_len_q <= '0;
    end else begin
      hs_len_q <= hs_len_q + CNT_W'(1);
    end
  end

  // length of the current low-side run, wraps harmlessly in sync mode
  logic [DLY_W-1:0] ls_len_q;
  always_ff @(posedge core_clk) begin
    if (srst || !ls_q) begin
      ls_len_q <= '0;
    end else begin
      ls_len_q <= ls_len_q + DLY_W'(1);
    end
  end

  // cycles since the last cycle start, kept apart from the period counter
  logic [CNT_W-1:0] since_start_q;
  always_ff @(posedge core_clk) begin
    if (srst || !run || cycle_start) begin
      since_start_q <= '0;
    end else begin
      since_start_q <= since_start_q + CNT_W'(1);
    end
  end

  sequence s_ls_dead;
    !ls_q [*6];
  endsequence
  sequence s_hs_dead;
    !hs_q [*6];
  endsequence

  property p_gap_after_high;
    @(posedge core_clk) disable iff (srst) $fell(hs_q) |-> s_ls_dead;
  endproperty
  a_gap_after_high: assert property (p_gap_after_high)
    else $error("low side on within dead time after high side");

  property p_gap_after_low;
    @(posedge core_clk) disable iff (srst) $fell(ls_q) |-> s_hs_dead;
  endproperty
  a_gap_after_low: assert property (p_gap_after_low)
    else $error("high side on within dead time after low side");

  property p_pulse_len;
    @(posedge core_clk) disable iff (srst || !run)
      (ls_q && state_q == S_LOW_PULSE) |=>
        (ls_q == (ls_len_q != DLY_W'(PULSE_CYCLES)));
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("recharge pulse length wrong");

  property p_max_on;
    @(posedge core_clk) disable iff (srst)
      hs_len_q < CNT_W'(PERIOD_CYCLES - MIN_OFF_CYCLES);
  endproperty
  a_max_on: assert property (p_max_on)
    else $error("high side on time exceeds limit");

  property p_restart;
    @(posedge core_clk) disable iff (srst) $rose(run) |=> step_q == 3'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("ramp did not restart at lowest step");

  property p_step_hold;
    @(posedge core_clk) disable iff (srst)
      (run && $past(run) && step_q != $past(step_q)) |->
        ($past(timer_q) == STEP_W'(STEP_CYCLES - 1) &&
         step_q == $past(step_q) + 3'h1);
  endproperty
  a_step_hold: assert property (p_step_hold)
    else $error("ramp step changed early");

  property p_stop;
    @(posedge core_clk) disable iff (srst)
      !run |=> (!hs_q && !ls_q && step_q == 3'h0);
  endproperty
  a_stop: assert property (p_stop)
    else $error("switching continued while disabled");

  property p_overvoltage;
    @(posedge core_clk) disable iff (srst)
      sense_q.adapter_overvoltage |=>
        (!path_q.adapter_switch_drive && path_q.battery_switch_drive);
  endproperty
  a_overvoltage: assert property (p_overvoltage)
    else $error("power path wrong during overvoltage");

  property p_monitor;
    @(posedge core_clk) disable iff (srst)
      !(sense_q.supply_above_5v && sense_q.adapter_above_0p6v) |=>
        !path_q.input_current_monitor_enable;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("current monitor enabled too early");

  property p_hyst;
    @(posedge core_clk) disable iff (srst)
      sense_q.current_below_fall |=> nonsync_q;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("undercurrent did not select non-synchronous");

  property p_refresh;
    @(posedge core_clk) disable iff (srst || !run)
      (begin_cycle && refresh_now) |=> !hs_q [*8];
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("high side on during bootstrap refresh");

  property p_period;
    @(posedge core_clk) disable iff (srst || !run)
      $past(run) |->
        (cycle_start == (since_start_q == CNT_W'(PERIOD_CYCLES - 1)));
  endproperty
  a_period: assert property (p_period)
    else $error("switching period wrong");

endmodule
`default_nettype wire

// [hdl/charger_pkg.sv]
// constants and carriers shared by the charger gate-drive control
package charger_pkg;

  // ****************************************************************
  // time base
  // ****************************************************************
  localparam int CLK_KHZ = 200000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SWITCH_KHZ = 300;
  localparam int PERIOD_CYCLES = CLK_KHZ / SWITCH_KHZ;
  localparam int CNT_W = 10;
  // max duty in hundredths of a percent
  localparam int MAX_DUTY_CENTI = 9998;
  localparam int MIN_OFF_RAW = PERIOD_CYCLES * (10000 - MAX_DUTY_CENTI) / 10000;
  localparam int MIN_OFF_CYCLES = (MIN_OFF_RAW < 1) ? 1 : MIN_OFF_RAW;
  localparam int DEAD_NS = 30;
  localparam int DEAD_CYCLES = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_NS = 80;
  localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
  localparam int DLY_W = 5;
  localparam int STEP_US = 1700;
  localparam int STEP_CYCLES_DEF = STEP_US * (CLK_KHZ / 1000);
  localparam int SS_STEPS = 8;
  localparam int BOOT_LOW_LIMIT = 3;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [2:0] STEP_RESET = 3'h0;
  localparam logic NONSYNC_RESET = 1'b1;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic charge_enable;
    logic select_adapter;
    logic error_above_ramp;
    logic bootstrap_low;
    logic current_below_fall;
    logic current_above_rise;
    logic adapter_overvoltage;
    logic supply_above_5v;
    logic adapter_above_0p6v;
  } sense_type;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } gate_type;

  typedef struct packed {
    logic adapter_switch_drive;
    logic battery_switch_drive;
    logic input_current_monitor_enable;
    logic input_overvoltage;
  } path_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DEAD_ON = 3'b001,
    S_HIGH = 3'b010,
    S_DEAD_OFF = 3'b011,
    S_LOW_SYNC = 3'b100,
    S_LOW_PULSE = 3'b101,
    S_REST = 3'b110
  } phase_type;

endpackage

// [bench/half_bridge_model.sv]
// model of the external half-bridge switches and bootstrap capacitor
`timescale 1ns/1ps
`default_nettype none
module half_bridge_model
  import charger_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire charger_pkg::gate_type gate_drive,
  input wire logic leak,
  output var logic bootstrap_low,
  output var logic [15:0] gap_faults
);
  // ****************************************************************
  // bootstrap capacitor and dead-time watch
  // ****************************************************************
  logic charged_q;
  logic [7:0] off_run_q;
  gate_type prev_q;

  assign bootstrap_low = ~charged_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      charged_q <= 1'b1;
      off_run_q <= 8'hff;
      prev_q <= '0;
      gap_faults <= 16'h0;
    end else begin
      // a failing capacitor outruns the recharge while leak is held
      if (leak) begin
        charged_q <= 1'b0;
      end else if (gate_drive.low_side_drive) begin
        charged_q <= 1'b1;
      end
      prev_q <= gate_drive;
      if (gate_drive == '0) begin
        off_run_q <= (off_run_q == 8'hff) ? off_run_q : off_run_q + 8'h1;
      end else begin
        off_run_q <= 8'h0;
      end
      // shoot-through or a short break-before-make gap
      if ((gate_drive.high_side_drive && gate_drive.low_side_drive) ||
          ((gate_drive & ~prev_q) != '0 && off_run_q < 8'(DEAD_CYCLES)))
      begin
        gap_faults <= gap_faults + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/buck_charger_gate_drive_control_bench.sv]
// self-checking bench for the charger gate-drive control
`timescale 1ns/1ps
`default_nettype none
module buck_charger_gate_drive_control_bench;
  import charger_pkg::*;
  localparam int STEP = 20;
  localparam int P = PERIOD_CYCLES;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic leak = 1'b0;
  sense_type pins = '0;
  sense_type sense_in;
  gate_type gate;
  path_type path;
  logic [2:0] step;
  logic nonsync;
  logic boot_low;
  logic [15:0] gap_faults;
  int bad_count = 0;
  int samples_checked = 0;
  int a;
  int b;

  always_comb begin
    sense_in = pins;
    sense_in.bootstrap_low = boot_low;
  end

  buck_charger_gate_drive_control #(.STEP_CYCLES(STEP), .STEP_W(19)) DUT (
    .core_clk(core_clk), .srst(srst), .sense_pins(sense_in),
    .gate_drive(gate), .path_drive(path), .current_step(step),
    .nonsync_mode(nonsync));

  half_bridge_model bridge (
    .core_clk(core_clk), .srst(srst), .gate_drive(gate), .leak(leak),
    .bootstrap_low(boot_low), .gap_faults(gap_faults));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_gate(input bit low, input logic lvl, input int bound,
                           output int n);
    logic g;
    n = 0;
    forever begin
      cycles(1);
      g = low ? gate.low_side_drive : gate.high_side_drive;
      if (g === lvl) begin
        return;
      end
      n++;
      if (n >= bound) begin
        bad_count++;
        $display("[FAIL] gate wait expected %0b seen %0b", lvl, g);
        tally_and_finish();
      end
    end
  endtask

  task automatic count_high(input int n, output int hs, output int ls);
    hs = 0;
    ls = 0;
    repeat (n) begin
      cycles(1);
      if (gate.high_side_drive === 1'b1) hs++;
      if (gate.low_side_drive === 1'b1) ls++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    cycles(1);
    check("gates in reset", 32'h0, 32'(gate));
    check("path in reset", 32'h0, 32'(path));
    check("step in reset", 32'(STEP_RESET), 32'(step));
    check("mode in reset", 32'(NONSYNC_RESET), 32'(nonsync));
    @(posedge core_clk);
    srst <= 1'b0;
  endtask

  task automatic t_path();
    @(posedge core_clk);
    pins.supply_above_5v <= 1'b1;
    cycles(4);
    check("monitor early", 32'h0, 32'(path.input_current_monitor_enable));
    @(posedge core_clk);
    pins.adapter_above_0p6v <= 1'b1;
    pins.select_adapter <= 1'b1;
    pins.charge_enable <= 1'b1;
    pins.error_above_ramp <= 1'b1;
    cycles(4);
    check("monitor on", 32'h1, 32'(path.input_current_monitor_enable));
    check("adapter on", 32'h1, 32'(path.adapter_switch_drive));
    @(posedge core_clk);
    pins.adapter_overvoltage <= 1'b1;
    cycles(4);
    check("ovp adapter", 32'h0, 32'(path.adapter_switch_drive));
    check("ovp battery", 32'h1, 32'(path.battery_switch_drive));
    check("ovp flag", 32'h1, 32'(path.input_overvoltage));
    count_high(P, a, b);
    check("ovp switching", 32'h0, 32'(a + b));
    @(posedge core_clk);
    pins.adapter_overvoltage <= 1'b0;
    wait_gate(1'b0, 1'b1, P + 40, a);
    check("ovp cleared", 32'h0, 32'(path.input_overvoltage));
    check("adapter back", 32'h1, 32'(path.adapter_switch_drive));
  endtask

  task automatic t_ramp();
    int n;
    @(posedge core_clk);
    pins.charge_enable <= 1'b0;
    cycles(4);
    @(posedge core_clk);
    pins.charge_enable <= 1'b1;
    cycles(4);
    check("ramp start", 32'h0, 32'(step));
    for (int k = 1; k < SS_STEPS; k++) begin
      n = 0;
      do begin
        cycles(1);
        n++;
      end while (step !== 3'(k) && n < 3 * STEP);
      check("ramp step", 32'(k), 32'(step));
      if (k > 1) check("step length", 32'(STEP), 32'(n));
    end
    cycles(2 * STEP);
    check("ramp top", 32'(SS_STEPS - 1), 32'(step));
    @(posedge core_clk);
    pins.charge_enable <= 1'b0;
    cycles(4);
    @(posedge core_clk);
    pins.charge_enable <= 1'b1;
    cycles(3 * STEP);
    @(posedge core_clk);
    pins.charge_enable <= 1'b0;
    cycles(4);
    check("abort step", 32'h0, 32'(step));
    check("abort gates", 32'h0, 32'(gate));
    @(posedge core_clk);
    pins.charge_enable <= 1'b1;
    cycles(4);
    check("restart step", 32'h0, 32'(step));
  endtask

  task automatic t_sync();
    @(posedge core_clk);
    pins.current_above_rise <= 1'b1;
    pins.current_below_fall <= 1'b0;
    cycles(2 * P);
    check("sync mode", 32'h0, 32'(nonsync));
    // start from a low phase so the high count covers a whole on-time
    wait_gate(1'b0, 1'b0, P, a);
    wait_gate(1'b0, 1'b1, P, a);
    wait_gate(1'b0, 1'b0, P, a);
    wait_gate(1'b0, 1'b1, P, b);
    check("period", 32'(P), 32'(a + b + 2));
    check("off at full duty", 32'(2 * DEAD_CYCLES), 32'(b + 1));
    @(posedge core_clk);
    pins.error_above_ramp <= 1'b0;
    cycles(2 * P);
    count_high(P, a, b);
    check("zero duty", 32'h0, 32'(a));
    check("low side held", 32'h1, 32'(b > P / 2));
    @(posedge core_clk);
    pins.error_above_ramp <= 1'b1;
  endtask

  task automatic t_nonsync();
    @(posedge core_clk);
    pins.current_above_rise <= 1'b0;
    pins.current_below_fall <= 1'b1;
    cycles(2 * P);
    check("nonsync mode", 32'h1, 32'(nonsync));
    wait_gate(1'b0, 1'b1, P, a);
    wait_gate(1'b0, 1'b0, P, a);
    wait_gate(1'b1, 1'b1, P, a);
    check("dead before pulse", 32'(DEAD_CYCLES), 32'(a + 1));
    wait_gate(1'b1, 1'b0, P, b);
    check("pulse width", 32'(PULSE_CYCLES), 32'(b + 1));
    count_high(P - 40, a, b);
    check("low side rests", 32'h0, 32'(b));
  endtask

  task automatic t_boot_nonsync();
    @(posedge core_clk);
    leak <= 1'b1;
    cycles(2 * P);
    count_high(P, a, b);
    check("refresh no high", 32'h0, 32'(a));
    check("refresh pulse", 32'(PULSE_CYCLES), 32'(b));
    @(posedge core_clk);
    leak <= 1'b0;
    wait_gate(1'b0, 1'b1, 3 * P, a);
  endtask

  task automatic t_boot_sync();
    @(posedge core_clk);
    pins.current_above_rise <= 1'b1;
    pins.current_below_fall <= 1'b0;
    cycles(2 * P);
    wait_gate(1'b0, 1'b1, P, a);
    @(posedge core_clk);
    leak <= 1'b1;
    @(posedge core_clk);
    leak <= 1'b0;
    wait_gate(1'b1, 1'b1, 6 * P, a);
    check("refresh late", 32'h1, 32'(a > 3 * P));
    check("refresh bound", 32'h1, 32'(a < 5 * P));
    check("refresh high off", 32'h0, 32'(gate.high_side_drive));
    wait_gate(1'b0, 1'b1, 2 * P, a);
  endtask

  initial begin
    t_reset();
    t_path();
    t_ramp();
    t_sync();
    t_nonsync();
    t_boot_nonsync();
    t_boot_sync();
    check("dead gaps", 32'h0, 32'(gap_faults));
    tally_and_finish();
  end
endmodule
`default_nettype wire
